// ===== verilog/shpp_top.sv
// Overview of operation
// - In slave mode the data-ready pin is high while a byte waits for the master, else low.
// - That pin is a plain general-purpose pin unless slave mode is selected.
// - MISO is an input in master mode and is driven by the port in slave mode.
// - MOSI is driven by the port in master mode and is an input in slave mode.
// - Select is active low, driven by the port as master and received as slave.
// - The SPI clock is made and driven by the port as master and received as slave.
// - The port is held in reset while its reset pin is low.
// - The flow-control output is low when another byte can be taken, high when not.
`timescale 1ns/1ps
module shpp_top #(
    parameter int unsigned FIFO_DEPTH = shpp_pkg::SHPP_FIFO_DEPTH
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       reset_n,
    input  wire logic       slave_mode_cfg,
    input  wire logic       gpio_out,
    input  wire logic       gpio_oe_n,
    output logic            gpio_in,
    input  wire logic       general_io_three_in,
    output logic            general_io_three_out,
    output logic            general_io_three_oe_n,
    input  wire logic       miso_in,
    output logic            miso_out,
    output logic            miso_oe_n,
    input  wire logic       mosi_in,
    output logic            mosi_out,
    output logic            mosi_oe_n,
    input  wire logic       ss_n_in,
    output logic            ss_n_out,
    output logic            ss_n_oe_n,
    input  wire logic       sclk_in,
    output logic            sclk_out,
    output logic            sclk_oe_n,
    output logic            host_cts_n,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic      [7:0] rx_data
);
    logic                      rst_i;
    logic                      rst_q;
    logic [1:0]                rstn_sync_q;
    logic [1:0]                ss_sync_q;
    logic [1:0]                miso_sync_q;
    logic [1:0]                gio_sync_q;
    logic [1:0]                tgl_sync_q;
    logic                      tgl_seen_q;
    logic                      byte_done;
    logic                      link_idle;
    logic                      mode_slave_q;
    logic                      fifo_valid;
    logic                      fifo_ready_c;
    logic [7:0]                fifo_data;
    logic                      take;
    logic                      mst_start;
    logic                      slv_capture;
    logic                      hold_valid_q;
    logic [7:0]                hold_data_q;
    logic                      rx_full_q;
    logic                      rx_full_d;
    logic [7:0]                rx_data_q;
    logic                      host_cts_n_q;
    shpp_pkg::shpp_mst_state_t mst_state_q;
    logic [3:0]                div_q;
    logic [3:0]                bits_q;
    logic [7:0]                shift_q;
    shpp_pkg::shpp_pin_drv_t   mosi_drv_q;
    shpp_pkg::shpp_pin_drv_t   ss_drv_q;
    shpp_pkg::shpp_pin_drv_t   sclk_drv_q;
    shpp_pkg::shpp_pin_drv_t   gio_drv_q;
    logic                      miso_oe_n_q;
    logic [3:0]                lk_pos_q;
    logic [7:0]                lk_tx_sh_q;
    logic                      lk_miso_q;
    logic [3:0]                lk_neg_q;
    logic [7:0]                lk_rx_sh_q;
    logic [7:0]                lk_rx_q;
    logic                      lk_tgl_q;

    // Reset pin passes two flops, then joins the core reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rstn_sync_q <= shpp_pkg::SHPP_SYNC_LOW;
        end else begin
            rstn_sync_q <= {rstn_sync_q[0], reset_n};
        end
    end
    assign rst_i = rst | ~rstn_sync_q[1];

    // Registered copy used as the reset of the link side's parked byte and toggle
    always_ff @(posedge ref_clk) begin
        rst_q <= rst_i;
    end

    // Pin and link-event synchronisers
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            ss_sync_q   <= shpp_pkg::SHPP_SYNC_HIGH;
            miso_sync_q <= shpp_pkg::SHPP_SYNC_LOW;
            gio_sync_q  <= shpp_pkg::SHPP_SYNC_LOW;
            tgl_sync_q  <= shpp_pkg::SHPP_SYNC_LOW;
            tgl_seen_q  <= 1'b0;
        end else begin
            ss_sync_q   <= {ss_sync_q[0], ss_n_in};
            miso_sync_q <= {miso_sync_q[0], miso_in};
            gio_sync_q  <= {gio_sync_q[0], general_io_three_in};
            tgl_sync_q  <= {tgl_sync_q[0], lk_tgl_q};
            tgl_seen_q  <= tgl_sync_q[1];
        end
    end
    assign byte_done = tgl_sync_q[1] ^ tgl_seen_q;
    assign link_idle = ss_sync_q[1];

    // Outgoing byte buffer
    shpp_fifo #(
        .WIDTH (shpp_pkg::SHPP_BYTE_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (ref_clk),
        .rst       (rst_i),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready_c),
        .out_data  (fifo_data)
    );

    // Buffer drains into the slave hold register or the master sequencer
    assign fifo_ready_c = mode_slave_q ? (!hold_valid_q && link_idle)
                        : (mst_state_q == shpp_pkg::SHPP_M_IDLE && !rx_full_q);
    assign take        = fifo_valid && fifo_ready_c;
    assign mst_start   = take && !mode_slave_q;
    assign slv_capture = mode_slave_q && byte_done;

    // Mode changes only with both the link and the sequencer at rest
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            mode_slave_q <= 1'b0;
        end else if (mst_state_q == shpp_pkg::SHPP_M_IDLE && link_idle && !take) begin
            mode_slave_q <= slave_mode_cfg;
        end
    end

    // Byte offered to the far master; a fresh load wins over a frame ending
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            hold_valid_q <= 1'b0;
            hold_data_q  <= shpp_pkg::SHPP_BYTE_ZERO;
        end else if (take && mode_slave_q) begin
            hold_valid_q <= 1'b1;
            hold_data_q  <= fifo_data;
        end else if (slv_capture) begin
            hold_valid_q <= 1'b0;
        end
    end

    // Received byte holding; a new byte wins over the user's take
    always_comb begin
        rx_full_d = rx_full_q;
        if (slv_capture || mst_state_q == shpp_pkg::SHPP_M_DONE) begin
            rx_full_d = 1'b1;
        end else if (rx_ready) begin
            rx_full_d = 1'b0;
        end
    end

    // Receive data and flow control
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            rx_full_q    <= 1'b0;
            rx_data_q    <= shpp_pkg::SHPP_BYTE_ZERO;
            host_cts_n_q <= 1'b1;
        end else begin
            rx_full_q    <= rx_full_d;
            host_cts_n_q <= rx_full_d;
            if (slv_capture) begin
                rx_data_q <= lk_rx_q;
            end else if (mst_state_q == shpp_pkg::SHPP_M_DONE) begin
                rx_data_q <= shift_q;
            end
        end
    end

    // Master sequencer: select, then eight clock periods
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            mst_state_q <= shpp_pkg::SHPP_M_IDLE;
            div_q       <= shpp_pkg::SHPP_CNT_ZERO;
            bits_q      <= shpp_pkg::SHPP_CNT_ZERO;
            shift_q     <= shpp_pkg::SHPP_BYTE_ZERO;
        end else begin
            case (mst_state_q)
                shpp_pkg::SHPP_M_IDLE: begin
                    if (mst_start) begin
                        shift_q     <= fifo_data;
                        div_q       <= shpp_pkg::SHPP_CNT_ZERO;
                        bits_q      <= shpp_pkg::SHPP_CNT_ZERO;
                        mst_state_q <= shpp_pkg::SHPP_M_SEL;
                    end
                end
                shpp_pkg::SHPP_M_SEL, shpp_pkg::SHPP_M_HIGH: begin
                    if (div_q == shpp_pkg::SHPP_HALF_LAST) begin
                        div_q       <= shpp_pkg::SHPP_CNT_ZERO;
                        mst_state_q <= (mst_state_q == shpp_pkg::SHPP_M_SEL)
                                     ? shpp_pkg::SHPP_M_HIGH : shpp_pkg::SHPP_M_LOW;
                    end else begin
                        div_q <= div_q + shpp_pkg::SHPP_CNT_ONE;
                    end
                end
                shpp_pkg::SHPP_M_LOW: begin
                    if (div_q == shpp_pkg::SHPP_HALF_LAST) begin
                        div_q       <= shpp_pkg::SHPP_CNT_ZERO;
                        shift_q     <= {shift_q[6:0], miso_sync_q[1]};
                        bits_q      <= bits_q + shpp_pkg::SHPP_CNT_ONE;
                        mst_state_q <= (bits_q == shpp_pkg::SHPP_BIT_LAST)
                                     ? shpp_pkg::SHPP_M_DONE : shpp_pkg::SHPP_M_HIGH;
                    end else begin
                        div_q <= div_q + shpp_pkg::SHPP_CNT_ONE;
                    end
                end
                shpp_pkg::SHPP_M_DONE: begin
                    mst_state_q <= shpp_pkg::SHPP_M_IDLE;
                end
                default: begin
                    mst_state_q <= shpp_pkg::SHPP_M_IDLE;
                end
            endcase
        end
    end

    // Pin directions and driven levels per mode
    always_ff @(posedge ref_clk) begin
        if (rst_i) begin
            mosi_drv_q  <= '{out: 1'b0, oe_n: shpp_pkg::SHPP_PIN_RELEASE};
            ss_drv_q    <= '{out: 1'b1, oe_n: shpp_pkg::SHPP_PIN_RELEASE};
            sclk_drv_q  <= '{out: 1'b0, oe_n: shpp_pkg::SHPP_PIN_RELEASE};
            gio_drv_q   <= '{out: 1'b0, oe_n: shpp_pkg::SHPP_PIN_RELEASE};
            miso_oe_n_q <= shpp_pkg::SHPP_PIN_RELEASE;
        end else begin
            miso_oe_n_q     <= !mode_slave_q;
            mosi_drv_q.oe_n <= mode_slave_q;
            mosi_drv_q.out  <= shift_q[7];
            ss_drv_q.oe_n   <= mode_slave_q;
            ss_drv_q.out    <= (mst_state_q == shpp_pkg::SHPP_M_IDLE ||
                                mst_state_q == shpp_pkg::SHPP_M_DONE);
            sclk_drv_q.oe_n <= mode_slave_q;
            sclk_drv_q.out  <= (mst_state_q == shpp_pkg::SHPP_M_HIGH);
            if (mode_slave_q) begin
                gio_drv_q <= '{out: hold_valid_q, oe_n: shpp_pkg::SHPP_PIN_DRIVE};
            end else begin
                gio_drv_q <= '{out: gpio_out, oe_n: gpio_oe_n};
            end
        end
    end

    // Link side, rising edge: shift the held byte out on MISO
    always_ff @(posedge sclk_in or posedge ss_n_in) begin
        if (ss_n_in) begin
            lk_pos_q   <= shpp_pkg::SHPP_CNT_ZERO;
            lk_tx_sh_q <= shpp_pkg::SHPP_BYTE_ZERO;
            lk_miso_q  <= 1'b0;
        end else begin
            if (lk_pos_q == shpp_pkg::SHPP_CNT_ZERO) begin
                lk_miso_q  <= hold_data_q[7];
                lk_tx_sh_q <= {hold_data_q[6:0], 1'b0};
            end else begin
                lk_miso_q  <= lk_tx_sh_q[7];
                lk_tx_sh_q <= {lk_tx_sh_q[6:0], 1'b0};
            end
            if (lk_pos_q != shpp_pkg::SHPP_BITS) begin
                lk_pos_q <= lk_pos_q + shpp_pkg::SHPP_CNT_ONE;
            end
        end
    end

    // Link side, falling edge: sample MOSI
    always_ff @(negedge sclk_in or posedge ss_n_in) begin
        if (ss_n_in) begin
            lk_neg_q   <= shpp_pkg::SHPP_CNT_ZERO;
            lk_rx_sh_q <= shpp_pkg::SHPP_BYTE_ZERO;
        end else begin
            lk_rx_sh_q <= {lk_rx_sh_q[6:0], mosi_in};
            if (lk_neg_q != shpp_pkg::SHPP_BITS) begin
                lk_neg_q <= lk_neg_q + shpp_pkg::SHPP_CNT_ONE;
            end
        end
    end

    // Completed byte is parked and announced by a toggle
    always_ff @(negedge sclk_in or posedge rst_q) begin
        if (rst_q) begin
            lk_rx_q  <= shpp_pkg::SHPP_BYTE_ZERO;
            lk_tgl_q <= 1'b0;
        end else if (!ss_n_in && lk_neg_q == shpp_pkg::SHPP_BIT_LAST) begin
            lk_rx_q  <= {lk_rx_sh_q[6:0], mosi_in};
            lk_tgl_q <= ~lk_tgl_q;
        end
    end

    // Outputs straight from flops
    assign gpio_in               = gio_sync_q[1];
    assign general_io_three_out  = gio_drv_q.out;
    assign general_io_three_oe_n = gio_drv_q.oe_n;
    assign miso_out              = lk_miso_q;
    assign miso_oe_n             = miso_oe_n_q;
    assign mosi_out              = mosi_drv_q.out;
    assign mosi_oe_n             = mosi_drv_q.oe_n;
    assign ss_n_out              = ss_drv_q.out;
    assign ss_n_oe_n             = ss_drv_q.oe_n;
    assign sclk_out              = sclk_drv_q.out;
    assign sclk_oe_n             = sclk_drv_q.oe_n;
    assign host_cts_n            = host_cts_n_q;
    assign rx_valid              = rx_full_q;
    assign rx_data               = rx_data_q;

    // Master frame: select held low for the first 8 reference clocks after it falls
    sequence s_mst_begin;
        mst_state_q == shpp_pkg::SHPP_M_IDLE && mst_start;
    endsequence
    sequence s_select_low;
        (ss_drv_q.out == 1'b0 && ss_drv_q.oe_n == 1'b0) [*8];
    endsequence

    a_master_select: assert property (@(posedge ref_clk) disable iff (rst_i)
        s_mst_begin |=> ##1 s_select_low)
        else $error("select not held low during master frame");
    a_master_clock: assert property (@(posedge ref_clk) disable iff (rst_i)
        (mst_state_q == shpp_pkg::SHPP_M_HIGH && !mode_slave_q) |=> sclk_drv_q.out)
        else $error("master clock not high in high phase");
    a_dav_high: assert property (@(posedge ref_clk) disable iff (rst_i)
        (mode_slave_q && hold_valid_q) |=> (gio_drv_q.out && !gio_drv_q.oe_n))
        else $error("data ready not shown while byte held");
    a_dav_low: assert property (@(posedge ref_clk) disable iff (rst_i)
        (mode_slave_q && !hold_valid_q) |=> !gio_drv_q.out)
        else $error("data ready high with nothing held");
    a_gpio_default: assert property (@(posedge ref_clk) disable iff (rst_i)
        !mode_slave_q |=> (gio_drv_q.out == $past(gpio_out) &&
                           gio_drv_q.oe_n == $past(gpio_oe_n)))
        else $error("general pin not following user control");
    a_miso_dir: assert property (@(posedge ref_clk) disable iff (rst_i)
        1'b1 |=> miso_oe_n_q == !$past(mode_slave_q))
        else $error("miso direction wrong for mode");
    a_slave_release: assert property (@(posedge ref_clk) disable iff (rst_i)
        $rose(mode_slave_q) |=> (mosi_drv_q.oe_n && ss_drv_q.oe_n && sclk_drv_q.oe_n))
        else $error("master pins still driven in slave mode");
    a_pin_reset: assert property (@(posedge ref_clk)
        !reset_n |=> ##1 rst_i)
        else $error("reset pin low did not reset the port");
    a_reset_idle: assert property (@(posedge ref_clk)
        rst_i |=> (mst_state_q == shpp_pkg::SHPP_M_IDLE && !hold_valid_q && host_cts_n_q))
        else $error("port not idle after reset");
    a_cts_flow: assert property (@(posedge ref_clk) disable iff (rst_i)
        (slv_capture || mst_state_q == shpp_pkg::SHPP_M_DONE) |=> (host_cts_n_q && rx_full_q))
        else $error("flow control not closed by a received byte");
    a_miso_first: assert property (@(posedge sclk_in) disable iff (ss_n_in || rst_q)
        lk_pos_q == shpp_pkg::SHPP_CNT_ZERO |=> lk_miso_q == $past(hold_data_q[7]))
        else $error("first slave bit not the held byte msb");

endmodule

// ===== verilog/shpp_pkg.sv
package shpp_pkg;

    // Data and buffer shape
    localparam int unsigned SHPP_BYTE_W     = 8;
    localparam int unsigned SHPP_FIFO_DEPTH = 4;

    // Master clock timing: reference period and SPI clock half period
    localparam int unsigned SHPP_REF_PERIOD_NS = 100;
    localparam int unsigned SHPP_SCLK_HALF_NS  = 400;
    localparam int unsigned SHPP_HALF_CYC      =
        (SHPP_SCLK_HALF_NS + SHPP_REF_PERIOD_NS - 1) / SHPP_REF_PERIOD_NS;

    // Counter widths and terminal counts
    localparam int unsigned SHPP_DIV_W   = 4;
    localparam int unsigned SHPP_CNT_W   = 4;
    localparam logic [3:0]  SHPP_HALF_LAST = 4'(SHPP_HALF_CYC - 1);
    localparam logic [3:0]  SHPP_BITS      = 4'h8;
    localparam logic [3:0]  SHPP_BIT_LAST  = 4'h7;
    localparam logic [3:0]  SHPP_CNT_ZERO  = 4'h0;
    localparam logic [3:0]  SHPP_CNT_ONE   = 4'h1;

    // Output enable levels (enable is active low)
    localparam logic SHPP_PIN_DRIVE   = 1'b0;
    localparam logic SHPP_PIN_RELEASE = 1'b1;

    // Reset values of the synchronisers and byte registers
    localparam logic [1:0] SHPP_SYNC_LOW  = 2'h0;
    localparam logic [1:0] SHPP_SYNC_HIGH = 2'h3;
    localparam logic [7:0] SHPP_BYTE_ZERO = 8'h00;

    // Master transfer sequencer
    typedef enum logic [2:0] {
        SHPP_M_IDLE,
        SHPP_M_SEL,
        SHPP_M_HIGH,
        SHPP_M_LOW,
        SHPP_M_DONE
    } shpp_mst_state_t;

    // Level and enable of one driven pin
    typedef struct packed {
        logic out;
        logic oe_n;
    } shpp_pin_drv_t;

endpackage

// ===== verilog/shpp_fifo.sv
`timescale 1ns/1ps
module shpp_fifo #(
    parameter int unsigned WIDTH = shpp_pkg::SHPP_BYTE_W,
    parameter int unsigned DEPTH = shpp_pkg::SHPP_FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             rdy_q;
    logic             push;
    logic             pop;

    // Handshakes on both sides
    assign push      = in_valid && rdy_q;
    assign pop       = out_valid && out_ready;
    assign in_ready  = rdy_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];

    // Fill level after this cycle
    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // Storage written at the tail
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers, level and registered ready
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW + 1)'(DEPTH));
        end
    end

endmodule

// ===== bench/shpp_far_end.sv
`timescale 1ns/1ps
module shpp_far_end #(
    parameter logic [7:0] REPLY = 8'h3c
) (
    input  wire logic ss_line,
    input  wire logic sclk_line,
    input  wire logic mosi_line,
    input  wire logic miso_line,
    output logic      m_ss_n,
    output logic      m_sclk,
    output logic      m_mosi,
    output logic      s_miso
);
    logic [7:0] s_sh;
    logic [7:0] s_got;

    // Idle master: deselected, clock parked low
    initial begin
        m_ss_n = 1'b1;
        m_sclk = 1'b0;
        m_mosi = 1'b0;
        s_miso = 1'b0;
    end

    // Far slave: reply loaded at select, one bit out per rising clock
    always @(negedge ss_line) s_sh = REPLY;
    always @(posedge sclk_line) begin
        if (!ss_line) begin
            s_miso <= s_sh[7];
            s_sh   <= {s_sh[6:0], 1'b0};
        end
    end
    // Deselected line no longer holds its last bit
    always @(posedge ss_line) s_miso <= ~s_miso;
    // Far slave samples the port's data on falling clock
    always @(negedge sclk_line) if (!ss_line) s_got <= {s_got[6:0], mosi_line};

    // Far master frame: 32 ns clock only inside the frame, MSB first
    task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        #7 m_ss_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #16 m_sclk = 1'b1;
            m_mosi = tx[i];
            #16 m_sclk = 1'b0;
            rx = {rx[6:0], miso_line};
        end
        #16 m_ss_n = 1'b1;
        m_mosi = ~m_mosi;
    endtask
endmodule

// ===== bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic       ref_clk, rst, reset_n, slave_mode_cfg, gpio_out, gpio_oe_n, gpio_in;
    logic       general_io_three_in, general_io_three_out, general_io_three_oe_n;
    logic       miso_in, miso_out, miso_oe_n, mosi_in, mosi_out, mosi_oe_n;
    logic       ss_n_in, ss_n_out, ss_n_oe_n, sclk_in, sclk_out, sclk_oe_n, host_cts_n;
    logic       tx_valid, tx_ready, rx_valid, rx_ready, m_ss_n, m_sclk, m_mosi, s_miso;
    logic [7:0] tx_data, rx_data, got;
    int         failures = 0;
    int         checks_done = 0;

    shpp_top #(.FIFO_DEPTH(shpp_pkg::SHPP_FIFO_DEPTH)) i_dut (
        .ref_clk, .rst, .reset_n, .slave_mode_cfg, .gpio_out, .gpio_oe_n, .gpio_in,
        .general_io_three_in, .general_io_three_out, .general_io_three_oe_n,
        .miso_in, .miso_out, .miso_oe_n, .mosi_in, .mosi_out, .mosi_oe_n,
        .ss_n_in, .ss_n_out, .ss_n_oe_n, .sclk_in, .sclk_out, .sclk_oe_n, .host_cts_n,
        .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_ready, .rx_data);
    shpp_far_end i_far (.ss_line(ss_n_in), .sclk_line(sclk_in), .mosi_line(mosi_in),
        .miso_line(miso_in), .m_ss_n, .m_sclk, .m_mosi, .s_miso);

    // Wire levels: the far side or the pull-up takes what the port releases
    assign ss_n_in = (ss_n_oe_n === shpp_pkg::SHPP_PIN_DRIVE) ? ss_n_out : m_ss_n;
    assign sclk_in = (sclk_oe_n === shpp_pkg::SHPP_PIN_DRIVE) ? sclk_out : m_sclk;
    assign mosi_in = (mosi_oe_n === shpp_pkg::SHPP_PIN_DRIVE) ? mosi_out : m_mosi;
    assign miso_in = (miso_oe_n === shpp_pkg::SHPP_PIN_DRIVE) ? miso_out : s_miso;
    assign general_io_three_in =
        (general_io_three_oe_n === shpp_pkg::SHPP_PIN_DRIVE) ? general_io_three_out : 1'b1;

    always #50 ref_clk = ~ref_clk;

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Level of a watched output: 0 select, 1 receive valid, else data ready
    function automatic logic probe(input int which);
        case (which)
            0: return ss_n_in;
            1: return rx_valid;
            default: return general_io_three_out;
        endcase
    endfunction

    task automatic wait_for(input string what, input int which, input logic lvl);
        int n;
        n = 0;
        while (probe(which) !== lvl && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        if (n >= 300) begin
            failures++;
            $display("[FAIL] %s expected %b seen timeout", what, lvl);
            wrap_up();
        end
    endtask

    // Take the received byte and see flow control reopen
    task automatic take_rx();
        rx_ready = 1'b1;
        @(negedge ref_clk);
        rx_ready = 1'b0;
        @(negedge ref_clk);
        chk("cts after take", 8'h00, host_cts_n);
        chk("rx taken", 8'h00, rx_valid);
    endtask

    // Port as master: it drives select, clock and MOSI, listens on MISO
    task automatic test_master();
        chk("gio oe master", 8'h00, general_io_three_oe_n);
        tx_data = 8'ha5;
        tx_valid = 1'b1;
        @(negedge ref_clk);
        tx_valid = 1'b0;
        wait_for("select low", 0, 1'b0);
        chk("gio level", 8'h01, gpio_in);
        chk("miso oe", 8'h01, miso_oe_n);
        chk("mosi oe", 8'h00, mosi_oe_n);
        chk("ss oe", 8'h00, ss_n_oe_n);
        chk("sclk oe", 8'h00, sclk_oe_n);
        wait_for("rx valid", 1, 1'b1);
        chk("rx master", 8'h3c, rx_data);
        chk("mosi byte", 8'ha5, i_far.s_got);
        chk("select idle", 8'h01, ss_n_out);
        take_rx();
        $display("test master done");
    endtask

    // Port as slave: fill the buffer, then the far master drains it
    task automatic test_slave();
        int k;
        slave_mode_cfg = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("gio oe slave", 8'h00, general_io_three_oe_n);
        chk("no data ready", 8'h00, general_io_three_out);
        chk("miso oe", 8'h00, miso_oe_n);
        chk("mosi oe", 8'h01, mosi_oe_n);
        chk("ss oe", 8'h01, ss_n_oe_n);
        chk("sclk oe", 8'h01, sclk_oe_n);
        k = 0;
        while (tx_ready === 1'b1 && k < 10) begin
            tx_data = 8'h10 + 8'(k);
            tx_valid = 1'b1;
            @(negedge ref_clk);
            k++;
        end
        tx_data = 8'hee;
        @(negedge ref_clk);
        tx_valid = 1'b0;
        chk("fifo refused", 8'(shpp_pkg::SHPP_FIFO_DEPTH + 1), 8'(k));
        for (int j = 0; j < k; j++) begin
            wait_for("data ready", 2, 1'b1);
            chk("cts open", 8'h00, host_cts_n);
            i_far.frame(8'h60 + 8'(j), got);
            chk("miso byte", 8'h10 + 8'(j), got);
            wait_for("rx valid", 1, 1'b1);
            chk("rx slave", 8'h60 + 8'(j), rx_data);
            chk("cts full", 8'h01, host_cts_n);
            take_rx();
            repeat (10) @(negedge ref_clk);
        end
        chk("drained", 8'h00, general_io_three_out);
        $display("test slave done");
    endtask

    // Reset pin held low puts MISO and the general pin back to released
    task automatic test_reset_pin();
        reset_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("miso oe in reset", 8'h01, miso_oe_n);
        chk("gio oe in reset", 8'h01, general_io_three_oe_n);
        chk("cts in reset", 8'h01, host_cts_n);
        reset_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        chk("miso oe after", 8'h00, miso_oe_n);
        $display("test reset pin done");
    endtask

    initial begin
        ref_clk = 1'b0;
        rst = 1'b1;
        reset_n = 1'b1;
        slave_mode_cfg = 1'b0;
        gpio_out = 1'b1;
        gpio_oe_n = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        rx_ready = 1'b0;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        test_master();
        test_slave();
        test_reset_pin();
        wrap_up();
    end
endmodule
